//--- omc_ctrl.sv
// Optical module control, status and two-wire management target
// Behaviour
// - Fault flag fast; long shutdown hold clears fault
// - Signal-lost output follows received signal quickly
// - Fault flag one on any laser fault
// - Transmitter on only while shutdown low
// - Presence line held at ground
// - Two definition lines carry serial clock, data
// - Serial bus serves identification and diagnostics
// - Five monitored values reported
// - Internal and external calibration both supported
// - Shutdown turns output off within 10 us
// - Release restores output within 1 ms
// - Initialisation clears fault within 300 ms
`timescale 1ns/1ps
module omc_ctrl import omc_pkg::*; #(
  parameter int INIT_LEN = INIT_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic tx_disable_i,
  input wire logic laser_fault_detect,
  input wire logic rx_signal_absent,
  input wire logic cal_external,
  input wire logic [15:0] mon_temp,
  input wire logic [15:0] mon_vcc,
  input wire logic [15:0] mon_bias,
  input wire logic [15:0] mon_tx_power,
  input wire logic [15:0] mon_rx_power,
  output logic laser_enable,
  output logic laser_fault_o,
  output logic laser_fault_oe_n,
  output logic optical_signal_lost_o,
  output logic optical_signal_lost_oe_n,
  output logic module_present_o,
  output logic module_present_oe_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);
  logic dis_s, fault_s, absent_s, ack_s;
  logic fault_reg, los_reg, armed_reg, init_busy_reg, req_tog_reg, laser_reg;
  logic [RESET_CNT_W-1:0] hold_cnt_reg;
  logic [INIT_CNT_W-1:0] init_cnt_reg;
  logic [15:0] raw [NUM_MON];
  logic [15:0] shown [NUM_MON];
  logic [15:0] snap_reg [NUM_MON];
  logic [7:0] snap_status_reg;
  logic snap_ext_reg;
  omc_sync u_sync_dis (.clk(core_clk), .d(tx_disable_i), .q(dis_s));
  omc_sync u_sync_flt (.clk(core_clk), .d(laser_fault_detect), .q(fault_s));
  omc_sync u_sync_los (.clk(core_clk), .d(rx_signal_absent), .q(absent_s));
  assign raw = '{mon_temp, mon_vcc, mon_bias, mon_tx_power, mon_rx_power}; // Page order
  // Internal mode applies the constants here; external mode passes raw counts
  for (genvar g = 0; g < NUM_MON; g++) begin : g_cal
    wire logic [31:0] scaled = raw[g] * CAL_SLOPE;
    wire logic [15:0] cal_val = scaled[SLOPE_FRAC+15:SLOPE_FRAC] + CAL_OFFSET;
    assign shown[g] = cal_external ? raw[g] : cal_val;
  end
  wire logic hold_done = (hold_cnt_reg == RESET_CNT_W'(RESET_CYCLES - 1));
  wire logic init_done = (init_cnt_reg == INIT_CNT_W'(INIT_LEN - 1));
  wire logic reset_pulse_end = armed_reg & ~dis_s;
  // Laser stays dark on a standing fault, but is tried during initialisation
  wire logic laser_next = ~dis_s & (~fault_reg | init_busy_reg);
  // Shutdown hold timer: the pulse must last long enough to count as a reset
  always_ff @(posedge core_clk) begin
    if (!reset_n || !dis_s) begin
      hold_cnt_reg <= '0;
    end else if (!hold_done) begin
      hold_cnt_reg <= hold_cnt_reg + 1'b1;
    end
  end
  // Arm on a long pulse, then run initialisation after its release
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      armed_reg <= 1'b0;
      init_busy_reg <= 1'b1;
      init_cnt_reg <= '0;
    end else begin
      armed_reg <= dis_s & (armed_reg | hold_done);
      if (reset_pulse_end) begin
        init_busy_reg <= 1'b1;
        init_cnt_reg <= '0;
      end else if (init_busy_reg) begin
        init_busy_reg <= ~init_done;
        init_cnt_reg <= init_cnt_reg + 1'b1;
      end
    end
  end
  // Fault flag: a detection always wins over the clear at end of initialisation
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fault_reg <= 1'b0;
    end else if (fault_s) begin
      fault_reg <= 1'b1;
    end else if (init_busy_reg && init_done) begin
      fault_reg <= 1'b0;
    end
  end
  // Pin-facing flops
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      los_reg <= 1'b1;
      laser_reg <= 1'b0;
    end else begin
      los_reg <= absent_s;
      laser_reg <= laser_next;
    end
  end
  assign laser_enable = laser_reg;
  // Open-collector pins: drive low for logic 0, release for logic 1
  assign laser_fault_o = 1'b0;
  assign laser_fault_oe_n = fault_reg;
  assign optical_signal_lost_o = 1'b0;
  assign optical_signal_lost_oe_n = los_reg;
  assign module_present_o = 1'b0;
  assign module_present_oe_n = 1'b0;
  // Snapshot handshake: hold words stay still while a request is outstanding
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      req_tog_reg <= 1'b0;
      snap_status_reg <= '0;
      snap_ext_reg <= 1'b0;
      for (int i = 0; i < NUM_MON; i++) snap_reg[i] <= '0;
    end else if (ack_s == req_tog_reg) begin
      req_tog_reg <= ~req_tog_reg;
      snap_ext_reg <= cal_external;
      snap_status_reg <= '0;
      snap_status_reg[ST_BIT_DISABLE] <= dis_s;
      snap_status_reg[ST_BIT_FAULT] <= fault_reg;
      snap_status_reg[ST_BIT_LOST] <= los_reg;
      for (int i = 0; i < NUM_MON; i++) snap_reg[i] <= shown[i];
    end
  end
  logic link_rst_n, req_s, scl_s, sda_s;
  logic scl_d_reg, sda_d_reg, ack_tog_reg, rnw_reg, diag_sel_reg, nack_reg;
  logic [15:0] mon_reg [NUM_MON];
  logic [7:0] status_reg, ofs_reg, shift_reg, tx_reg;
  logic ext_reg, sda_oe_n_reg;
  logic [3:0] bit_cnt_reg;
  omc_state_t state_reg;
  omc_sync u_sync_rst (.clk(link_clk), .d(reset_n), .q(link_rst_n));
  omc_sync u_sync_req (.clk(link_clk), .d(req_tog_reg), .q(req_s));
  omc_sync u_sync_ack (.clk(core_clk), .d(ack_tog_reg), .q(ack_s));
  omc_sync u_sync_scl (.clk(link_clk), .d(scl_i), .q(scl_s));
  omc_sync u_sync_sda (.clk(link_clk), .d(sda_i), .q(sda_s));
  // Take the snapshot once the request toggle has crossed
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      ack_tog_reg <= 1'b0;
      status_reg <= '0;
      ext_reg <= 1'b0;
      for (int i = 0; i < NUM_MON; i++) mon_reg[i] <= '0;
    end else if (req_s != ack_tog_reg) begin
      ack_tog_reg <= req_s;
      status_reg <= snap_status_reg;
      ext_reg <= snap_ext_reg;
      for (int i = 0; i < NUM_MON; i++) mon_reg[i] <= snap_reg[i];
    end
  end
  // Byte lookup for both pages
  function automatic logic [7:0] read_byte(input logic diag, input logic [7:0] ofs);
    logic [7:0] rel, b;
    b = 8'h00;
    if (!diag) begin
      if (ofs == ID_OFS_IDENT) b = ID_VAL_IDENT;
      else if (ofs == ID_OFS_EXT_IDENT) b = ID_VAL_EXT_IDENT;
      else if (ofs == ID_OFS_DIAG_TYPE) b = ext_reg ? DIAG_TYPE_EXTERNAL : DIAG_TYPE_INTERNAL;
    end else if (ofs >= DIAG_CAL_BASE && ofs <= DIAG_CAL_END) begin
      rel = ofs - DIAG_CAL_BASE;
      case (rel[1:0])
        2'h0: b = CAL_SLOPE[15:8];
        2'h1: b = CAL_SLOPE[7:0];
        2'h2: b = CAL_OFFSET[15:8];
        default: b = CAL_OFFSET[7:0];
      endcase
    end else if (ofs >= DIAG_MON_BASE && ofs <= DIAG_MON_END) begin
      rel = ofs - DIAG_MON_BASE;
      b = rel[0] ? mon_reg[rel[3:1]][7:0] : mon_reg[rel[3:1]][15:8];
    end else if (ofs == DIAG_OFS_STATUS) begin
      b = status_reg;
    end
    return b;
  endfunction : read_byte
  wire logic scl_rise = scl_s & ~scl_d_reg;
  wire logic scl_fall = ~scl_s & scl_d_reg;
  wire logic start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire logic stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire logic byte_done = bit_cnt_reg[3];
  wire logic is_id = (shift_reg[7:1] == ID_DEV_ADDR);
  wire logic is_diag = (shift_reg[7:1] == DIAG_DEV_ADDR);
  logic [7:0] rd_byte;
  // A process, not a net, so the lookup also wakes when the snapshot words move
  always_comb rd_byte = read_byte(diag_sel_reg, ofs_reg);
  // Two-wire target; host pacing of the serial clock is trusted
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      state_reg <= OMC_IDLE;
      sda_oe_n_reg <= 1'b1;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      tx_reg <= '0;
      ofs_reg <= '0;
      rnw_reg <= 1'b0;
      diag_sel_reg <= 1'b0;
      nack_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      if (start_cond) begin
        state_reg <= OMC_ADDR;
        bit_cnt_reg <= '0;
        sda_oe_n_reg <= 1'b1;
      end else if (stop_cond) begin
        state_reg <= OMC_IDLE;
        sda_oe_n_reg <= 1'b1;
      end else if (scl_rise) begin
        if (state_reg == OMC_ADDR || state_reg == OMC_WOFS) begin
          shift_reg <= {shift_reg[6:0], sda_s};
          bit_cnt_reg <= bit_cnt_reg + 1'b1;
        end else if (state_reg == OMC_RD) begin
          bit_cnt_reg <= bit_cnt_reg + 1'b1;
        end else if (state_reg == OMC_RACK) begin
          nack_reg <= sda_s;
        end
      end else if (scl_fall) begin
        case (state_reg)
          OMC_ADDR: begin
            if (byte_done) begin
              bit_cnt_reg <= '0;
              if (is_id || is_diag) begin
                state_reg <= OMC_AACK;
                diag_sel_reg <= is_diag;
                rnw_reg <= shift_reg[0];
                sda_oe_n_reg <= 1'b0;
              end else begin
                state_reg <= OMC_IDLE;
              end
            end
          end
          OMC_AACK: begin
            if (rnw_reg) begin
              state_reg <= OMC_RD;
              tx_reg <= rd_byte;
              sda_oe_n_reg <= rd_byte[7];
            end else begin
              state_reg <= OMC_WOFS;
              sda_oe_n_reg <= 1'b1;
            end
          end
          OMC_WOFS: begin
            if (byte_done) begin
              state_reg <= OMC_OACK;
              ofs_reg <= shift_reg;
              bit_cnt_reg <= '0;
              sda_oe_n_reg <= 1'b0;
            end
          end
          OMC_OACK: begin
            state_reg <= OMC_IDLE; // Further written bytes are not acknowledged
            sda_oe_n_reg <= 1'b1;
          end
          OMC_RD: begin
            if (byte_done) begin
              state_reg <= OMC_RACK;
              ofs_reg <= ofs_reg + 1'b1;
              bit_cnt_reg <= '0;
              sda_oe_n_reg <= 1'b1;
            end else begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              sda_oe_n_reg <= tx_reg[6];
            end
          end
          OMC_RACK: begin
            if (!nack_reg) begin
              state_reg <= OMC_RD;
              tx_reg <= rd_byte;
              sda_oe_n_reg <= rd_byte[7];
            end else begin
              state_reg <= OMC_IDLE;
            end
          end
          default: state_reg <= state_reg;
        endcase
      end
    end
  end
  assign sda_o = 1'b0;
  assign sda_oe_n = sda_oe_n_reg;
endmodule : omc_ctrl

//--- omc_ctrl_sva.sv
// Assertion checker for the optical module control block
`timescale 1ns/1ps
module omc_ctrl_sva (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic tx_disable_i,
  input wire logic laser_fault_detect,
  input wire logic rx_signal_absent,
  input wire logic laser_enable,
  input wire logic laser_fault_o,
  input wire logic laser_fault_oe_n,
  input wire logic optical_signal_lost_o,
  input wire logic optical_signal_lost_oe_n,
  input wire logic module_present_o,
  input wire logic module_present_oe_n,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_n
);
  // Three steady cycles cover the two sync flops and the output register
  sequence s_dis3;
    tx_disable_i [*3];
  endsequence
  sequence s_lost3;
    rx_signal_absent [*3];
  endsequence
  sequence s_seen3;
    !rx_signal_absent [*3];
  endsequence
  // Open-drain pins may only pull low
  property p_od;
    @(posedge core_clk) disable iff (!reset_n) !laser_fault_o && !sda_o && !optical_signal_lost_o; endproperty
  a_od: assert property (p_od) else $error("open drain pin driven high");
  property p_present;
    @(posedge core_clk) disable iff (!reset_n) !module_present_o && !module_present_oe_n; endproperty
  a_present: assert property (p_present) else $error("presence not grounded");
  property p_fault;
    @(posedge core_clk) disable iff (!reset_n) $rose(laser_fault_detect) |-> ##[1:3] laser_fault_oe_n; endproperty
  a_fault: assert property (p_fault) else $error("fault flag late");
  property p_off;
    @(posedge core_clk) disable iff (!reset_n) s_dis3 |=> !laser_enable; endproperty
  a_off: assert property (p_off) else $error("laser still on");
  property p_on;
    @(posedge core_clk) disable iff (!reset_n) $rose(laser_enable) |-> !$past(tx_disable_i, 3); endproperty
  a_on: assert property (p_on) else $error("laser on while shut down");
  property p_lost;
    @(posedge core_clk) disable iff (!reset_n) s_lost3 |=> optical_signal_lost_oe_n; endproperty
  a_lost: assert property (p_lost) else $error("signal loss not shown");
  property p_seen;
    @(posedge core_clk) disable iff (!reset_n) s_seen3 |=> !optical_signal_lost_oe_n; endproperty
  a_seen: assert property (p_seen) else $error("signal loss stuck");
  property p_clr;
    @(posedge core_clk) disable iff (!reset_n) $fell(laser_fault_oe_n) |-> !$past(laser_fault_detect, 3); endproperty
  a_clr: assert property (p_clr) else $error("fault cleared while present");
  // Target data may only move while the serial clock is low
  property p_sda;
    @(posedge link_clk) disable iff (!reset_n) $changed(sda_oe_n) |-> !scl_i; endproperty
  a_sda: assert property (p_sda) else $error("data moved with clock high");
endmodule : omc_ctrl_sva

bind omc_ctrl omc_ctrl_sva i_sva (.core_clk(core_clk), .reset_n(reset_n), .link_clk(link_clk),
  .tx_disable_i(tx_disable_i), .laser_fault_detect(laser_fault_detect), .rx_signal_absent(rx_signal_absent),
  .laser_enable(laser_enable), .laser_fault_o(laser_fault_o), .laser_fault_oe_n(laser_fault_oe_n),
  .optical_signal_lost_o(optical_signal_lost_o), .optical_signal_lost_oe_n(optical_signal_lost_oe_n),
  .module_present_o(module_present_o), .module_present_oe_n(module_present_oe_n), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n));

//--- omc_host.sv
// Two-wire bus master standing in for the host board
`timescale 1ns/1ps
module omc_host (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  localparam realtime HALF = 1250.0;
  logic [7:0] q[$];
  logic nak;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Data moves mid-low so it never races the clock edge
  task automatic bit_x(input logic b, output logic r);
    #(HALF / 2);
    sda_low = !b;
    #(HALF / 2);
    scl = 1'b1;
    #(HALF / 2);
    r = sda;
    #(HALF / 2);
    scl = 1'b0;
  endtask : bit_x
  // Start or repeated start
  task automatic start;
    #(HALF / 2);
    sda_low = 1'b0;
    #(HALF / 2);
    scl = 1'b1;
    #(HALF);
    sda_low = 1'b1;
    #(HALF);
    scl = 1'b0;
  endtask : start
  task automatic stop;
    #(HALF / 2);
    sda_low = 1'b1;
    #(HALF / 2);
    scl = 1'b1;
    #(HALF);
    sda_low = 1'b0;
    #(HALF);
  endtask : stop
  task automatic byte_x(input logic [7:0] b, input logic last, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bit_x(b[i], r[i]);
    bit_x(last, a);
  endtask : byte_x
  // Offset write, repeated start, reads ended by NACK
  task automatic rd(input logic [6:0] dev, input logic [7:0] ofs, input int n);
    logic [7:0] r;
    logic a;
    q.delete();
    start();
    byte_x({dev, 1'b0}, 1'b1, r, nak);
    if (!nak) begin
      byte_x(ofs, 1'b1, r, a);
      start();
      byte_x({dev, 1'b1}, 1'b1, r, a);
      for (int k = 0; k < n; k++) begin
        byte_x(8'hFF, k == n - 1, r, a);
        q.push_back(r);
      end
    end
    stop();
  endtask : rd
endmodule : omc_host

//--- omc_pkg.sv
// Shared constants for the optical module control and management block
package omc_pkg;
  // Clock rates
  localparam int CORE_CLK_MHZ = 200;
  // Documented timing figures in their own units
  localparam int T_FAULT_US = 100;
  localparam int T_RESET_US = 10;
  localparam int T_LOSS_US = 100;
  localparam int T_OFF_US = 10;
  localparam int T_ON_MS = 1;
  localparam int T_INIT_MS = 300;
  localparam int SERIAL_CLK_MAX_KHZ = 400;
  // Least shutdown hold that resets a fault, rounded up
  localparam int RESET_CYCLES = T_RESET_US * CORE_CLK_MHZ;
  localparam int RESET_CNT_W = 12;
  // Longest initialisation time, rounded down
  localparam int INIT_CYCLES = T_INIT_MS * 1000 * CORE_CLK_MHZ;
  localparam int INIT_CNT_W = 26;
  // Two-wire target addresses (7-bit)
  localparam logic [6:0] ID_DEV_ADDR = 7'h50;
  localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;
  // Identification memory contents
  localparam logic [7:0] ID_OFS_IDENT = 8'h00;
  localparam logic [7:0] ID_VAL_IDENT = 8'h03;
  localparam logic [7:0] ID_OFS_EXT_IDENT = 8'h01;
  localparam logic [7:0] ID_VAL_EXT_IDENT = 8'h04;
  localparam logic [7:0] ID_OFS_DIAG_TYPE = 8'h5C;
  localparam logic [7:0] DIAG_TYPE_INTERNAL = 8'h60;
  localparam logic [7:0] DIAG_TYPE_EXTERNAL = 8'h50;
  // Diagnostic page layout
  localparam int NUM_MON = 5;
  localparam logic [7:0] DIAG_CAL_BASE = 8'h38;
  localparam logic [7:0] DIAG_CAL_END = 8'h4B;
  localparam logic [7:0] DIAG_MON_BASE = 8'h60;
  localparam logic [7:0] DIAG_MON_END = 8'h69;
  localparam logic [7:0] DIAG_OFS_STATUS = 8'h6E;
  localparam int ST_BIT_DISABLE = 7;
  localparam int ST_BIT_FAULT = 2;
  localparam int ST_BIT_LOST = 1;
  // Calibration constants, slope in 8.8 fixed point
  localparam logic [15:0] CAL_SLOPE = 16'h0100;
  localparam logic [15:0] CAL_OFFSET = 16'h0000;
  localparam int SLOPE_FRAC = 8;
  // Two-wire target states
  typedef enum logic [6:0] {
    OMC_IDLE = 7'b000_0001,
    OMC_ADDR = 7'b000_0010,
    OMC_AACK = 7'b000_0100,
    OMC_WOFS = 7'b000_1000,
    OMC_OACK = 7'b001_0000,
    OMC_RD = 7'b010_0000,
    OMC_RACK = 7'b100_0000
  } omc_state_t;
endpackage : omc_pkg

//--- omc_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
module omc_sync (
  input wire logic clk,
  input wire logic d,
  output logic q
);
  logic meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    meta_reg <= d;
    q <= meta_reg;
  end
endmodule : omc_sync

//--- test_optical_module_ctrl_status.sv
// Self-checking bench for the optical module control block
`timescale 1ns/1ps
module test_optical_module_ctrl_status;
  import omc_pkg::*;
  logic core_clk = 0;
  logic link_clk = 0;
  logic reset_n = 0;
  logic tx_disable_i = 0;
  logic laser_fault_detect = 0;
  logic rx_signal_absent = 0;
  logic cal_external = 0;
  logic [15:0] mon [5] = '{default: 16'h0000};
  logic laser_enable, laser_fault_o, laser_fault_oe_n, optical_signal_lost_o, optical_signal_lost_oe_n;
  logic module_present_o, module_present_oe_n, sda_o, sda_oe_n, scl, host_low;
  int mismatches = 0;
  int num_checks = 0;
  // Pulled-up data line, low when either side pulls
  wire sda = !(host_low || !sda_oe_n);
  always #2.5 core_clk = ~core_clk;
  always #6 link_clk = ~link_clk;
  omc_ctrl #(.INIT_LEN(50)) i_dut (.core_clk(core_clk), .reset_n(reset_n), .link_clk(link_clk),
    .tx_disable_i(tx_disable_i), .laser_fault_detect(laser_fault_detect), .rx_signal_absent(rx_signal_absent),
    .cal_external(cal_external), .mon_temp(mon[0]), .mon_vcc(mon[1]), .mon_bias(mon[2]),
    .mon_tx_power(mon[3]), .mon_rx_power(mon[4]), .laser_enable(laser_enable), .laser_fault_o(laser_fault_o),
    .laser_fault_oe_n(laser_fault_oe_n), .optical_signal_lost_o(optical_signal_lost_o),
    .optical_signal_lost_oe_n(optical_signal_lost_oe_n), .module_present_o(module_present_o),
    .module_present_oe_n(module_present_oe_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
  omc_host i_host (.scl(scl), .sda_low(host_low), .sda(sda));
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait for the transmitter to reach a level
  task automatic wait_en(input logic v);
    int k;
    k = 0;
    while (laser_enable !== v) begin
      if (k++ > 400) begin
        mismatches++;
        conclude();
      end
      cyc(1);
    end
  endtask : wait_en
  // Shutdown held n cycles, then released and init allowed to finish
  task automatic pulse(input int n);
    tx_disable_i = 1;
    cyc(n);
    tx_disable_i = 0;
    cyc(63);
  endtask : pulse
  function automatic logic [7:0] mon_byte(input int i);
    logic [15:0] v;
    v = 16'((32'(mon[i / 2]) * CAL_SLOPE) >> SLOPE_FRAC) + CAL_OFFSET;
    if (cal_external) v = mon[i / 2];
    return i[0] ? v[7:0] : v[15:8];
  endfunction : mon_byte
  initial begin
    void'($urandom(32'h5558f4ff));
    cyc(16);
    reset_n = 1;
    cyc(60);
    chk(16'(module_present_oe_n), 16'h0000);
    chk(16'(laser_fault_oe_n), 16'h0000);
    wait_en(1);
    repeat (4) begin
      tx_disable_i = 1;
      cyc(4 + $urandom_range(20));
      chk(16'(laser_enable), 16'h0000);
      tx_disable_i = 0;
      wait_en(1);
    end
    rx_signal_absent = 1;
    cyc(4);
    chk(16'(optical_signal_lost_oe_n), 16'h0001);
    rx_signal_absent = 0;
    cyc(4);
    chk(16'(optical_signal_lost_oe_n), 16'h0000);
    laser_fault_detect = 1;
    cyc(5);
    chk(16'(laser_fault_oe_n), 16'h0001);
    chk(16'(laser_enable), 16'h0000);
    pulse(RESET_CYCLES + 3);
    chk(16'(laser_fault_oe_n), 16'h0001);
    laser_fault_detect = 0;
    pulse(100);
    chk(16'(laser_fault_oe_n), 16'h0001);
    // Shortest hold that resets, with the fault gone: the flag must clear
    pulse(RESET_CYCLES);
    chk(16'(laser_fault_oe_n), 16'h0000);
    wait_en(1);
    // Random monitor words read back over the serial bus
    foreach (mon[i]) mon[i] = 16'($urandom);
    cal_external = 1'($urandom);
    cyc(20);
    i_host.rd(DIAG_DEV_ADDR, DIAG_MON_BASE, 2 * NUM_MON);
    chk(16'(i_host.nak), 16'h0000);
    for (int i = 0; i < 2 * NUM_MON; i++) chk(16'(i_host.q[i]), 16'(mon_byte(i)));
    // Other calibration scheme for the type byte, read once and checked against the code that matches it
    cal_external = ~cal_external;
    cyc(20);
    i_host.rd(ID_DEV_ADDR, ID_OFS_DIAG_TYPE, 1);
    chk(16'(i_host.q[0]), 16'(cal_external ? DIAG_TYPE_EXTERNAL : DIAG_TYPE_INTERNAL));
    i_host.rd(7'h52, 8'h00, 1);
    chk(16'(i_host.nak), 16'h0001);
    conclude();
  end
endmodule : test_optical_module_ctrl_status
